// >>> hw/uvepc_cfg.svh
// timing and layout constants for the uv eprom host controller
// assumes a 100 MHz clock, 10 ns period
`ifndef UVEPC_CFG_SVH
`define UVEPC_CFG_SVH
`define UVEPC_CLK_PERIOD_NS 10
`define UVEPC_ADDR_W 11
`define UVEPC_DATA_W 8
`define UVEPC_ERASED_BYTE 8'hFF
// read access: longest of the three output delays, in ns
`define UVEPC_ADDR_TO_OUT_NS 450
`define UVEPC_EN_TO_OUT_NS 450
`define UVEPC_OE_TO_OUT_NS 120
// programming timing
`define UVEPC_SETUP_US 2
`define UVEPC_HOLD_US 2
`define UVEPC_PULSE_MIN_MS 45
`define UVEPC_PULSE_MAX_MS 55
`define UVEPC_PULSE_NOM_MS 50
`define UVEPC_READ_CYC ((`UVEPC_ADDR_TO_OUT_NS + `UVEPC_CLK_PERIOD_NS - 1) / `UVEPC_CLK_PERIOD_NS + 1)
`define UVEPC_SETUP_CYC ((`UVEPC_SETUP_US * 1000 + `UVEPC_CLK_PERIOD_NS - 1) / `UVEPC_CLK_PERIOD_NS)
`define UVEPC_HOLD_CYC ((`UVEPC_HOLD_US * 1000 + `UVEPC_CLK_PERIOD_NS - 1) / `UVEPC_CLK_PERIOD_NS)
`define UVEPC_PULSE_CYC ((`UVEPC_PULSE_NOM_MS * 1000000) / `UVEPC_CLK_PERIOD_NS)
`endif

// >>> hw/uvepc_pkg.sv
// types for the uv eprom host controller
// assumes uvepc_cfg.svh for widths
`include "uvepc_cfg.svh"
package uvepc_pkg;
  typedef enum logic [2:0] {
    UVEPC_IDLE,
    UVEPC_RD_WAIT,
    UVEPC_PG_SETUP,
    UVEPC_PG_PULSE,
    UVEPC_PG_HOLD,
    UVEPC_VF_WAIT,
    UVEPC_DONE
  } uvepc_state_t;
endpackage : uvepc_pkg

// >>> hw/uvepc_ctrl.sv
// host controller driving a 2048 x 8 uv eprom through its pins
// assumes pin inputs synchronous to clk; the program supply switch is external
`timescale 1ns/10ps
`include "uvepc_cfg.svh"
module uvepc_ctrl
  import uvepc_pkg::*;
#(
  parameter int PULSE_CYC = `UVEPC_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic pg_req,
  input wire logic pg_verify,
  input wire logic [`UVEPC_ADDR_W-1:0] req_addr,
  input wire logic [`UVEPC_DATA_W-1:0] req_data,
  input wire logic [`UVEPC_DATA_W-1:0] byte_lines_i,
  output logic [`UVEPC_DATA_W-1:0] byte_lines_o,
  output logic byte_lines_oe,
  output logic [`UVEPC_ADDR_W-1:0] location_select_inputs,
  output logic chip_enable_program,
  output logic output_enable_n,
  output logic prog_supply_high,
  output logic busy,
  output logic done,
  output logic [`UVEPC_DATA_W-1:0] rd_data,
  output logic pg_fail
);

  // ----------------------------------------
  // timing
  // ----------------------------------------
  // the read wait covers the slowest of the address, enable and output enable delays
  localparam logic [22:0] READ_CYC = 23'(`UVEPC_READ_CYC);
  localparam logic [22:0] SETUP_CYC = 23'(`UVEPC_SETUP_CYC);
  localparam logic [22:0] HOLD_CYC = 23'(`UVEPC_HOLD_CYC);
  localparam logic [22:0] PULSE_LEN = 23'(PULSE_CYC);

  // ----------------------------------------
  // state and counters
  // ----------------------------------------
  uvepc_state_t state_r;
  logic [22:0] cnt_r;
  logic verify_r;
  logic [`UVEPC_DATA_W-1:0] wdata_r;

  function automatic logic cnt_last(input logic [22:0] cnt, input logic [22:0] lim);
    cnt_last = (cnt == lim - 23'h1);
  endfunction : cnt_last

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // a long pulse counter keeps the program pin high for exactly one nominal width,
  // so it can never stay high past the maximum even if requests keep coming
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= UVEPC_IDLE;
      cnt_r <= 23'h0;
      verify_r <= 1'b0;
      wdata_r <= `UVEPC_ERASED_BYTE;
    end else begin
      unique case (state_r)
        UVEPC_IDLE: begin
          cnt_r <= 23'h0;
          // program wins when both requests rise together
          if (pg_req) begin
            state_r <= UVEPC_PG_SETUP;
            verify_r <= pg_verify;
            wdata_r <= req_data;
          end else if (rd_req) begin
            state_r <= UVEPC_RD_WAIT;
          end
        end
        UVEPC_RD_WAIT: begin
          cnt_r <= cnt_r + 23'h1;
          if (cnt_last(cnt_r, READ_CYC)) begin
            state_r <= UVEPC_DONE;
          end
        end
        UVEPC_PG_SETUP: begin
          cnt_r <= cnt_r + 23'h1;
          if (cnt_last(cnt_r, SETUP_CYC)) begin
            state_r <= UVEPC_PG_PULSE;
            cnt_r <= 23'h0;
          end
        end
        UVEPC_PG_PULSE: begin
          cnt_r <= cnt_r + 23'h1;
          if (cnt_last(cnt_r, PULSE_LEN)) begin
            state_r <= UVEPC_PG_HOLD;
            cnt_r <= 23'h0;
          end
        end
        UVEPC_PG_HOLD: begin
          cnt_r <= cnt_r + 23'h1;
          if (cnt_last(cnt_r, HOLD_CYC)) begin
            cnt_r <= 23'h0;
            state_r <= verify_r ? UVEPC_VF_WAIT : UVEPC_DONE;
          end
        end
        UVEPC_VF_WAIT: begin
          cnt_r <= cnt_r + 23'h1;
          if (cnt_last(cnt_r, READ_CYC)) begin
            state_r <= UVEPC_DONE;
          end
        end
        UVEPC_DONE: begin
          state_r <= UVEPC_IDLE;
          cnt_r <= 23'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // address and data are held through setup, pulse and hold so that
  // the device sees them stable on both sides of the pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      location_select_inputs <= '0;
    end else if (state_r == UVEPC_IDLE && (pg_req || rd_req)) begin
      location_select_inputs <= req_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chip_enable_program <= 1'b1;
      output_enable_n <= 1'b1;
      byte_lines_o <= '0;
      byte_lines_oe <= 1'b0;
      prog_supply_high <= 1'b0;
    end else begin
      unique case (state_r)
        UVEPC_IDLE: begin
          // standby between requests: low power, device outputs float
          chip_enable_program <= ~(pg_req || rd_req);
          output_enable_n <= ~(rd_req && !pg_req);
          byte_lines_oe <= pg_req;
          byte_lines_o <= req_data;
          prog_supply_high <= pg_req;
        end
        UVEPC_PG_SETUP: begin
          chip_enable_program <= cnt_last(cnt_r, SETUP_CYC);
        end
        UVEPC_PG_PULSE: begin
          chip_enable_program <= ~cnt_last(cnt_r, PULSE_LEN);
        end
        UVEPC_PG_HOLD: begin
          chip_enable_program <= 1'b0;
          // data is released only once the hold time has run out
          if (cnt_last(cnt_r, HOLD_CYC) && verify_r) begin
            byte_lines_oe <= 1'b0;
            output_enable_n <= 1'b0;
          end
        end
        UVEPC_DONE: begin
          // everything returns to standby on one edge, supply never before the enables
          chip_enable_program <= 1'b1;
          output_enable_n <= 1'b1;
          byte_lines_oe <= 1'b0;
          prog_supply_high <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      rd_data <= `UVEPC_ERASED_BYTE;
      pg_fail <= 1'b0;
    end else begin
      // requests seen while busy are dropped, not queued
      busy <= (state_r == UVEPC_IDLE) ? (pg_req || rd_req) : (state_r != UVEPC_DONE);
      done <= 1'b0;
      if (state_r == UVEPC_IDLE && pg_req) begin
        pg_fail <= 1'b0;
      end
      if (state_r == UVEPC_RD_WAIT && cnt_last(cnt_r, READ_CYC)) begin
        rd_data <= byte_lines_i;
        done <= 1'b1;
      end
      if (state_r == UVEPC_PG_HOLD && cnt_last(cnt_r, HOLD_CYC) && !verify_r) begin
        done <= 1'b1;
      end
      // rd_data stands until the next read or verify reports; pg_fail stands until the next program request is accepted
      if (state_r == UVEPC_VF_WAIT && cnt_last(cnt_r, READ_CYC)) begin
        rd_data <= byte_lines_i;
        pg_fail <= (byte_lines_i != wdata_r);
        done <= 1'b1;
      end
    end
  end

endmodule : uvepc_ctrl

// >>> test/uvepc_ctrl_sva.sv
// pin checker for the uv eprom host controller
// assumes a bind into uvepc_ctrl, pulse counted in clk cycles
`timescale 1ns/10ps
module uvepc_chk #(parameter int PULSE_CYC = 50) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic done,
  input wire logic pg_fail,
  input wire logic chip_enable_program,
  input wire logic output_enable_n,
  input wire logic prog_supply_high,
  input wire logic byte_lines_oe,
  input wire logic [7:0] byte_lines_o,
  input wire logic [10:0] location_select_inputs
);
  wire ce = chip_enable_program;
  wire oe_n = output_enable_n;
  wire vpp = prog_supply_high;
  int hi_r, lo_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // counters, since a pulse window is far too long to unroll
  always_ff @(posedge clk) hi_r <= (ce && vpp) ? hi_r + 1 : 0;
  always_ff @(posedge clk) lo_r <= ce ? 0 : lo_r + 1;
  a_read_pins: assert property (busy && !oe_n |-> !ce && !byte_lines_oe) else $error("read pins");
  a_drive_prog: assert property (byte_lines_oe |-> oe_n && vpp) else $error("drive outside program");
  a_pulse_max: assert property (hi_r <= PULSE_CYC) else $error("pulse too long");
  a_pulse_width: assert property ($fell(ce) && $past(busy) && vpp |-> hi_r == PULSE_CYC)
    else $error("pulse width");
  a_setup_time: assert property ($rose(ce) && busy |-> lo_r >= 200) else $error("setup short");
  a_read_wait: assert property ($rose(busy) && !oe_n |-> ##46 done) else $error("read timing");
  a_done_standby: assert property (done |=> ce && oe_n && !byte_lines_oe) else $error("no standby");
  a_supply_idle: assert property (!busy && !done |-> !vpp) else $error("supply high when idle");
  a_hold_pins: assert property (byte_lines_oe && $past(byte_lines_oe) |->
    $stable(byte_lines_o) && $stable(location_select_inputs)) else $error("pins moved");
  c_read: cover property ($rose(busy) && !oe_n);
  c_pulse: cover property ($fell(ce) && vpp && $past(busy));
  c_fail: cover property ($rose(pg_fail));
endmodule : uvepc_chk
bind uvepc_ctrl uvepc_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk(clk), .rst_n(rst_n), .busy(busy), .done(done),
  .pg_fail(pg_fail), .chip_enable_program(chip_enable_program), .output_enable_n(output_enable_n),
  .prog_supply_high(prog_supply_high), .byte_lines_oe(byte_lines_oe), .byte_lines_o(byte_lines_o),
  .location_select_inputs(location_select_inputs));

// >>> test/uvepc_eprom.sv
// behavioural 2048 x 8 uv eprom on the controller pins
// assumes clk only times the access and pulse counters
`timescale 1ns/10ps
module uvepc_eprom #(parameter int ACC = 45, parameter int PW_MIN = 45, parameter int PW_MAX = 55) (
  input wire logic clk,
  input wire logic ce,
  input wire logic oe_n,
  input wire logic vpp,
  input wire logic inhibit,
  input wire logic [10:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] q,
  output logic q_en
);
  logic [7:0] mem [2048];
  int acc_r, pw_r;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge clk) begin
    acc_r <= (ce || oe_n) ? 0 : acc_r + 1;
    pw_r <= ce ? pw_r + 1 : 0;
    // only a pulse of legal width clears bits, so a bad pulse shows as a verify miss
    if (!ce && pw_r >= PW_MIN && pw_r <= PW_MAX && vpp && oe_n && !inhibit) begin
      mem[addr] <= mem[addr] & din;
    end
  end
  assign q_en = !ce && !oe_n;
  assign q = (acc_r >= ACC) ? mem[addr] : ~mem[addr];
endmodule : uvepc_eprom

// >>> test/tb.sv
// self-checking bench for the uv eprom host controller
// assumes the device model and checker compile before it
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_n = 0, rd_req = 0, pg_req = 0, pg_verify = 0, inhibit = 0;
  logic [10:0] req_addr = 11'h000, location_select_inputs, a;
  logic [7:0] req_data = 8'h00, byte_lines_i, byte_lines_o, rd_data, q, d, last_rd = 8'hFF;
  logic byte_lines_oe, chip_enable_program, output_enable_n, prog_supply_high, busy, done, pg_fail, q_en;
  logic [7:0] sh [2048];
  logic [9:0] nt [$];
  logic [9:0] note;
  int n_fail = 0, n_compared = 0, seed = 86754;
  always #5 clk = ~clk;
  // no pull on the data lines: a floating bus shows the inverse byte
  assign byte_lines_i = byte_lines_oe ? byte_lines_o : (q_en ? q : ~q);
  uvepc_ctrl #(.PULSE_CYC(50)) u_dut (.clk(clk), .rst_n(rst_n), .rd_req(rd_req), .pg_req(pg_req), .pg_verify(pg_verify),
    .req_addr(req_addr), .req_data(req_data), .byte_lines_i(byte_lines_i), .byte_lines_o(byte_lines_o),
    .byte_lines_oe(byte_lines_oe), .location_select_inputs(location_select_inputs),
    .chip_enable_program(chip_enable_program), .output_enable_n(output_enable_n), .prog_supply_high(prog_supply_high),
    .busy(busy), .done(done), .rd_data(rd_data), .pg_fail(pg_fail));
  uvepc_eprom u_rom (.clk(clk), .ce(chip_enable_program), .oe_n(output_enable_n), .vpp(prog_supply_high),
    .inhibit(inhibit), .addr(location_select_inputs), .din(byte_lines_i), .q(q), .q_en(q_en));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task xfer(input logic rd, input logic pg, input logic vf, input logic [10:0] ad, input logic [7:0] dt);
    logic [7:0] e;
    if (pg && !inhibit) sh[ad] = sh[ad] & dt;
    e = ((rd && !pg) || (pg && vf)) ? sh[ad] : last_rd; // a program request wins over a read
    last_rd = e;
    nt.push_back({pg, e, vf && sh[ad] !== dt});
    @(posedge clk);
    #1;
    {rd_req, pg_req, pg_verify, req_addr, req_data} = {rd, pg, vf, ad, dt};
    @(posedge clk);
    #1;
    {rd_req, pg_req} = 2'b00;
    check({7'h00, busy}, 8'h01);
    for (int n = 0; n < 700 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check({7'h00, done}, 8'h01);
  endtask : xfer
  always @(negedge clk) begin
    if (done === 1'b1 && nt.size() > 0) begin
      note = nt.pop_front();
      check(rd_data, note[8:1]);
      if (note[9]) check({7'h00, pg_fail}, {7'h00, note[0]});
    end else if (done === 1'b1) begin
      check({7'h00, done}, 8'h00);
    end
  end
  initial begin
    foreach (sh[i]) sh[i] = 8'hFF;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1;
    xfer(1, 0, 0, 11'h000, 8'h00);
    xfer(1, 0, 0, 11'h7FF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      a = 11'($random(seed));
      d = 8'($random(seed));
      xfer(0, 1, i[0], a, d);
      xfer(1, 0, 0, a, 8'h00);
      xfer(0, 1, 0, a, ~d ^ 8'h0F);
      xfer(1, 0, 0, a, 8'h00);
    end
    inhibit = 1;
    xfer(0, 1, 1, a + 11'h001, 8'h5A);
    inhibit = 0;
    xfer(0, 1, 1, a + 11'h001, 8'h5A);
    xfer(1, 1, 0, a + 11'h002, 8'hC3);
    xfer(1, 0, 0, a + 11'h002, 8'h00);
    repeat (2) @(posedge clk);
    check(8'(nt.size()), 8'h00);
    test_done();
  end
  initial begin
    #300000;
    n_fail++;
    test_done();
  end
endmodule : tb
